/* File: common/gfm_pkg.sv */
/*
   Shared constants and bundles for the pin function multiplexer.
   Assumes a single 250 MHz clock and a 12-bit AXI4-Lite byte address.
*/
package gfm_pkg;
   // ------------------------------------------------------------
   // Sizes and register map
   // ------------------------------------------------------------
   localparam int NUM_PINS = 5;
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_DSP1_CFG = 12'h440;
   localparam logic [11:0] ADDR_DSP2_CFG = 12'h550;
   localparam logic [11:0] ADDR_PIN_BASE = 12'h700;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h720;
   localparam logic [11:0] ADDR_RAW_STATUS = 12'h724;
   localparam logic [3:0] SEL_DSP1 = 4'h5;
   localparam logic [3:0] SEL_DSP2 = 4'h6;
   localparam logic [3:0] SEL_IRQ = 4'h7;
   localparam logic [3:0] SEL_RAW = 4'h8;
   localparam logic [3:0] SEL_NONE = 4'hF;
   // ------------------------------------------------------------
   // Pin control fields
   // ------------------------------------------------------------
   localparam int DIR_BIT = 15;
   localparam int INV_BIT = 10;
   localparam int OD_BIT = 9;
   localparam int DB_BIT = 8;
   localparam int LVL_BIT = 6;
   localparam int FN_MSB = 4;
   localparam logic [15:0] PIN_RESET = 16'h8101;
   localparam logic [15:0] PIN_WMASK = 16'h875F;
   // ------------------------------------------------------------
   // Activity detect fields
   // ------------------------------------------------------------
   localparam int ACT_RMS_LSB = 11;
   localparam int ACT_CREST_LSB = 9;
   localparam int ACT_MODE_BIT = 7;
   localparam int ACT_EN_BIT = 6;
   localparam logic [15:0] ACT_RESET = 16'h0000;
   localparam logic [15:0] ACT_WMASK = 16'hFEC0;
   localparam logic signed [15:0] RMS_BASE_DDB = -16'sd300;
   localparam logic signed [15:0] RMS_STEP_DDB = 16'sd15;
   localparam logic signed [15:0] CREST_BASE_DDB = 16'sd120;
   localparam logic signed [15:0] CREST_STEP_DDB = 16'sd60;
   // ------------------------------------------------------------
   // Function codes
   // ------------------------------------------------------------
   localparam logic [4:0] FN_ADC_LR_CLOCK = 5'h00;
   localparam logic [4:0] FN_LEVEL = 5'h01;
   localparam logic [4:0] FN_FIRST_RESERVED = 5'h0F;
   // ------------------------------------------------------------
   // Interrupt status bits
   // ------------------------------------------------------------
   localparam int IRQ_MIC = 5;
   localparam int IRQ_HP = 6;
   localparam int IRQ_ACT1 = 7;
   localparam int IRQ_ACT2 = 8;
   localparam int IRQ_W = 9;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int MIC_PULSE_NS = 31000;
   localparam int MIC_PULSE_CYC = MIC_PULSE_NS / CLK_PERIOD_NS;
   localparam int DB_TICKS_DEFAULT = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // Bundles
   // ------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } gfm_axi_req_type;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } gfm_axi_rsp_type;
   typedef struct packed {
      logic adc_lr_clock_if1;
      logic adc_lr_clock_if2;
      logic mic_event;
      logic hp_start;
      logic hp_done;
      logic [1:0] range_controller_en;
      logic [1:0] activity_raw;
      logic fifo_error;
      logic wseq_idle;
      logic servo_pair1_done;
      logic servo_pair2_done;
      logic clk_switch_done;
      logic freq_loop_lock;
      logic divided_sys_clock_out;
      logic freq_loop_clock;
   } gfm_core_type;
   typedef struct packed {
      logic en;
      logic mode;
      logic signed [15:0] threshold_ddb;
   } gfm_act_cfg_type;
endpackage

/* File: src/gfm_debounce.sv */
/*
   Input debounce filter for one pin.
   Assumes level_in is already synchronised and tick_in is a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module gfm_debounce #(
   parameter int TICKS = 4
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Control
   input wire logic enable_in,
   input wire logic tick_in,
   // Level
   input wire logic level_in,
   output logic level_out
);
   localparam int CW = $clog2(TICKS + 1);
   logic [CW-1:0] count_reg;
   logic state_reg;
   wire differs = level_in != state_reg;
   wire settled = tick_in && (count_reg == CW'(TICKS - 1));

   // Stability counter and filtered state
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count_reg <= '0;
         state_reg <= 1'b0;
      end else if (!enable_in || (differs && settled)) begin
         count_reg <= '0;
         state_reg <= level_in;
      end else if (!differs) begin
         count_reg <= '0;
      end else if (tick_in) begin
         count_reg <= count_reg + CW'(1);
      end
   end

   assign level_out = state_reg;
endmodule
`default_nettype wire

/* File: src/gfm_top.sv */
/*
   Pin function multiplexer with level I/O, debounce, latched edge flags and
   activity detect configuration, reached over AXI4-Lite.
   Assumes core status inputs are on clk_in; pins are asynchronous.
*/
// How it works
// - Level bit writes output, reads input
// - Inversion applies after level for outputs
// - Level readback debounced, not inverted
// - Five-bit function select resets to one
// - Code 00 routes interface left-right clocks to pins 0/1
// - Code 01 level output or input
// - Code 02 drives interrupt request state
// - Code 03 gives 31us mic pulse
// - Code 04 low during headphone measurement
// - Codes 05/06 give activity flags
// - Code 07 gives FIFO error flag
// - Code 08 gives sequencer idle flag
// - Codes 09/0A give servo done flags
// - Codes 0B/0C clock switch, loop lock
// - Codes 0D/0E clocks; rest reserved
// - Pin edges both ways latch flags
// - Mic and headphone events latch flags
// - Activity flags latch on rising edge
// - Activity needs controller and enable bit
// - RMS threshold -30dB minus 1.5dB steps
// - Crest threshold 12 to 30dB
// - Direction bit 15, resets to input
// - Bit 9 selects open drain
`timescale 1ns/10ps
`default_nettype none
module gfm_top import gfm_pkg::*; #(
   parameter int MIC_PULSE_CYCLES = MIC_PULSE_CYC,
   parameter int DB_TICKS = DB_TICKS_DEFAULT
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Register bus
   input wire gfm_axi_req_type axi_req_in,
   output var gfm_axi_rsp_type axi_rsp_out,
   // Pins
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe_out,
   // Core status and debounce tick
   input wire logic timeout_clock_in,
   input wire gfm_core_type core_in,
   // Activity detect configuration and flags
   output var gfm_act_cfg_type [1:0] activity_cfg_out,
   output logic [1:0] activity_flag_out
);
   localparam int MW = $clog2(MIC_PULSE_CYCLES + 1);

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   // Address to register select
   function automatic logic [3:0] gfm_decode(input logic [11:0] addr);
      logic [3:0] sel;
      sel = SEL_NONE;
      for (int k = 0; k < NUM_PINS; k++) begin
         if (addr == ADDR_PIN_BASE + 12'(4 * k)) begin
            sel = 4'(k);
         end
      end
      if (addr == ADDR_DSP1_CFG) sel = SEL_DSP1;
      if (addr == ADDR_DSP2_CFG) sel = SEL_DSP2;
      if (addr == ADDR_IRQ_STATUS) sel = SEL_IRQ;
      if (addr == ADDR_RAW_STATUS) sel = SEL_RAW;
      return sel;
   endfunction

   // Threshold in tenths of a dB for the selected comparison
   function automatic logic signed [15:0] gfm_threshold(input logic [15:0] cfg);
      logic signed [15:0] rms;
      logic signed [15:0] crest;
      rms = 16'($signed({11'h000, cfg[ACT_RMS_LSB+:5]}));
      crest = 16'($signed({14'h0000, cfg[ACT_CREST_LSB+:2]}));
      if (cfg[ACT_MODE_BIT]) begin
         return 16'(RMS_BASE_DDB - rms * RMS_STEP_DDB);
      end
      return 16'(CREST_BASE_DDB + crest * CREST_STEP_DDB);
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [15:0] pin_cfg_reg [NUM_PINS];
   logic [15:0] act_cfg_reg [2];
   logic [IRQ_W-1:0] irq_status_reg;
   logic [NUM_PINS-1:0] pin_meta_reg, pin_sync_reg, pin_db, pin_db_prev_reg;
   logic [NUM_PINS-1:0] pin_out_reg, pin_oe_reg;
   logic [MW-1:0] mic_cnt_reg;
   logic mic_event_prev_reg, hp_status_reg, hp_prev_reg;
   logic [1:0] act_flag_reg, act_prev_reg;
   logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;

   // ------------------------------------------------------------
   // AXI4-Lite handshakes
   // ------------------------------------------------------------
   wire aw_take = axi_req_in.awvalid && !aw_full_reg;
   wire w_take = axi_req_in.wvalid && !w_full_reg;
   wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   wire ar_take = axi_req_in.arvalid && !rvalid_reg;
   wire [3:0] wr_sel = gfm_decode(aw_addr_reg);
   wire [3:0] rd_sel = gfm_decode(axi_req_in.araddr);
   wire [15:0] lane_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [15:0] wr_data = w_data_reg[15:0];

   // Address and data holding, response generation
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (aw_take) aw_addr_reg <= axi_req_in.awaddr;
         if (w_take) begin
            w_data_reg <= axi_req_in.wdata;
            w_strb_reg <= axi_req_in.wstrb;
         end
         aw_full_reg <= do_write ? 1'b0 : (aw_full_reg || aw_take);
         w_full_reg <= do_write ? 1'b0 : (w_full_reg || w_take);
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (axi_req_in.bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read data capture
   logic [15:0] rd_word;
   always_comb begin
      rd_word = 16'h0000;
      for (int k = 0; k < NUM_PINS; k++) begin
         if (rd_sel == 4'(k)) begin
            rd_word = pin_cfg_reg[k];
            // Inputs show the filtered pin, outputs the stored level
            rd_word[LVL_BIT] = pin_cfg_reg[k][DIR_BIT] ? pin_db[k]
                                                      : pin_cfg_reg[k][LVL_BIT];
         end
      end
      if (rd_sel == SEL_DSP1) rd_word = act_cfg_reg[0];
      if (rd_sel == SEL_DSP2) rd_word = act_cfg_reg[1];
      if (rd_sel == SEL_IRQ) rd_word = {7'h00, irq_status_reg};
      if (rd_sel == SEL_RAW) rd_word = {8'h00, act_flag_reg, hp_status_reg, pin_db};
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {16'h0000, rd_word};
         rresp_reg <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (axi_req_in.rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign axi_rsp_out.awready = !aw_full_reg;
   assign axi_rsp_out.wready = !w_full_reg;
   assign axi_rsp_out.bvalid = bvalid_reg;
   assign axi_rsp_out.bresp = bresp_reg;
   assign axi_rsp_out.arready = !rvalid_reg;
   assign axi_rsp_out.rvalid = rvalid_reg;
   assign axi_rsp_out.rdata = rdata_reg;
   assign axi_rsp_out.rresp = rresp_reg;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // Masked byte-lane writes; reset gives input, debounced, level mode
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int k = 0; k < NUM_PINS; k++) pin_cfg_reg[k] <= PIN_RESET;
         act_cfg_reg[0] <= ACT_RESET;
         act_cfg_reg[1] <= ACT_RESET;
      end else if (do_write) begin
         for (int k = 0; k < NUM_PINS; k++) begin
            if (wr_sel == 4'(k)) begin
               pin_cfg_reg[k] <= (pin_cfg_reg[k] & ~(PIN_WMASK & lane_mask))
                                 | (wr_data & PIN_WMASK & lane_mask);
            end
         end
         for (int d = 0; d < 2; d++) begin
            if (wr_sel == (d == 0 ? SEL_DSP1 : SEL_DSP2)) begin
               act_cfg_reg[d] <= (act_cfg_reg[d] & ~(ACT_WMASK & lane_mask))
                                 | (wr_data & ACT_WMASK & lane_mask);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Event sources
   // ------------------------------------------------------------
   wire mic_rise = core_in.mic_event && !mic_event_prev_reg;
   wire mic_pulse = mic_cnt_reg != '0;
   wire [1:0] act_raw_gated = core_in.activity_raw & core_in.range_controller_en
                              & {act_cfg_reg[1][ACT_EN_BIT], act_cfg_reg[0][ACT_EN_BIT]};

   // Mic pulse timer, headphone status, activity flags
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         mic_cnt_reg <= '0;
         mic_event_prev_reg <= 1'b0;
         hp_status_reg <= 1'b1;
         hp_prev_reg <= 1'b1;
         act_flag_reg <= 2'h0;
         act_prev_reg <= 2'h0;
      end else begin
         mic_event_prev_reg <= core_in.mic_event;
         if (mic_rise) begin
            mic_cnt_reg <= MW'(MIC_PULSE_CYCLES);
         end else if (mic_pulse) begin
            mic_cnt_reg <= mic_cnt_reg - MW'(1);
         end
         if (core_in.hp_done) begin
            hp_status_reg <= 1'b1;
         end else if (core_in.hp_start) begin
            hp_status_reg <= 1'b0;
         end
         hp_prev_reg <= hp_status_reg;
         act_flag_reg <= act_raw_gated;
         act_prev_reg <= act_flag_reg;
      end
   end

   // Latched flags: edges set, write-one clears, set wins
   wire [IRQ_W-1:0] irq_set = {act_flag_reg & ~act_prev_reg,
                               hp_status_reg && !hp_prev_reg, mic_rise,
                               pin_db ^ pin_db_prev_reg};
   wire [IRQ_W-1:0] irq_clr = (do_write && wr_sel == SEL_IRQ)
                              ? (wr_data[IRQ_W-1:0] & lane_mask[IRQ_W-1:0]) : '0;
   wire irq_line = |irq_status_reg;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         irq_status_reg <= '0;
         pin_db_prev_reg <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
         pin_db_prev_reg <= pin_db;
      end
   end

   // ------------------------------------------------------------
   // Pin paths
   // ------------------------------------------------------------
   // Two-stage synchroniser on the pin inputs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Per pin: debounce, function mux, polarity and driver style
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      wire [4:0] fn = pin_cfg_reg[i][FN_MSB:0];
      wire adc_clk = (i == 0) ? core_in.adc_lr_clock_if1
                   : (i == 1) ? core_in.adc_lr_clock_if2 : 1'b0;
      wire [14:0] src = {core_in.freq_loop_clock, core_in.divided_sys_clock_out,
                         core_in.freq_loop_lock, core_in.clk_switch_done,
                         core_in.servo_pair2_done, core_in.servo_pair1_done,
                         core_in.wseq_idle, core_in.fifo_error,
                         act_flag_reg[1], act_flag_reg[0], hp_status_reg,
                         mic_pulse, irq_line, pin_cfg_reg[i][LVL_BIT],
                         adc_clk};
      // Reserved codes give a constant low
      wire func = (fn < FN_FIRST_RESERVED) ? src[fn[3:0]] : 1'b0;
      wire ext = func ^ pin_cfg_reg[i][INV_BIT];
      wire drive = !pin_cfg_reg[i][DIR_BIT];
      wire od = pin_cfg_reg[i][OD_BIT];

      gfm_debounce #(.TICKS(DB_TICKS)) u_db (
         .clk_in(clk_in),
         .reset_in(reset_in),
         .enable_in(pin_cfg_reg[i][DB_BIT]),
         .tick_in(timeout_clock_in),
         .level_in(pin_sync_reg[i]),
         .level_out(pin_db[i])
      );

      // Open drain only ever pulls low
      always_ff @(posedge clk_in) begin
         if (reset_in) begin
            pin_out_reg[i] <= 1'b0;
            pin_oe_reg[i] <= 1'b0;
         end else begin
            pin_out_reg[i] <= od ? 1'b0 : ext;
            pin_oe_reg[i] <= drive && (!od || !ext);
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign pin_out = pin_out_reg;
   assign pin_oe_out = pin_oe_reg;
   assign activity_flag_out = act_flag_reg;
   for (genvar d = 0; d < 2; d++) begin : g_act
      assign activity_cfg_out[d].en = act_cfg_reg[d][ACT_EN_BIT];
      assign activity_cfg_out[d].mode = act_cfg_reg[d][ACT_MODE_BIT];
      assign activity_cfg_out[d].threshold_ddb = gfm_threshold(act_cfg_reg[d]);
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   property p_mic_load;
      mic_rise |=> mic_cnt_reg == MW'(MIC_PULSE_CYCLES);
   endproperty
   a_mic_load: assert property (p_mic_load) else $error("mic pulse not loaded");

   property p_mic_end;
      $fell(mic_pulse) |-> $past(mic_cnt_reg) == MW'(1) && !$past(mic_rise);
   endproperty
   a_mic_end: assert property (p_mic_end) else $error("mic pulse ended early");

   property p_set_wins;
      (|irq_set) |=> (irq_status_reg & $past(irq_set)) == $past(irq_set);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag event lost");

   property p_hp_low;
      core_in.hp_start && !core_in.hp_done
         |=> !hp_status_reg ##1 irq_set[IRQ_HP] == $past(core_in.hp_done);
   endproperty
   a_hp_low: assert property (p_hp_low) else $error("headphone status not low");

   property p_act_gate;
      !act_cfg_reg[0][ACT_EN_BIT] || !core_in.range_controller_en[0] |=> !act_flag_reg[0];
   endproperty
   a_act_gate: assert property (p_act_gate) else $error("activity flag ungated");

   property p_act_irq;
      $rose(act_flag_reg[0]) |=> irq_status_reg[IRQ_ACT1];
   endproperty
   a_act_irq: assert property (p_act_irq) else $error("activity flag not latched");

   wire fn_res0 = pin_cfg_reg[0][FN_MSB:0] >= FN_FIRST_RESERVED;
   property p_reserved;
      fn_res0 && !pin_cfg_reg[0][OD_BIT] && !pin_cfg_reg[0][DIR_BIT]
         |=> pin_oe_out[0] && pin_out[0] == $past(pin_cfg_reg[0][INV_BIT]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code not low");

   property p_od_low;
      pin_oe_out[0] && $past(pin_cfg_reg[0][OD_BIT]) |-> !pin_out[0];
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain drove high");

   property p_input_float;
      pin_cfg_reg[1][DIR_BIT] |=> !pin_oe_out[1];
   endproperty
   a_input_float: assert property (p_input_float) else $error("input pin driven");

   property p_bhold;
      bvalid_reg && !axi_req_in.bready |=> bvalid_reg && $stable(bresp_reg);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
`default_nettype wire

/* File: verif/gfm_pin_partner.sv */
/*
   Far-side model of buttons or logic on the five pins.
   Assumes a pull-up on each pin line and one outside driver per pin.
*/
`timescale 1ns/10ps
`default_nettype none
module gfm_pin_partner import gfm_pkg::*; (
   // Device side
   input wire logic [NUM_PINS-1:0] pin_out_in,
   input wire logic [NUM_PINS-1:0] pin_oe_in,
   // Outside drive
   input wire logic [NUM_PINS-1:0] ext_level_in,
   input wire logic [NUM_PINS-1:0] ext_oe_in,
   // Resolved wire
   output logic [NUM_PINS-1:0] pin_level_out
);
   // Device first, else outside part, else the pull-up
   assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_oe_in & ext_level_in)
      | (~pin_oe_in & ~ext_oe_in);
endmodule
`default_nettype wire

/* File: verif/gpio_function_mux_status_tb.sv */
/*
   Self-checking bench for the pin function multiplexer.
   Assumes the pin partner model and shortened pulse and debounce counts.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module gpio_function_mux_status_tb import gfm_pkg::*;;
   logic clk_in = 1'b0, reset_in = 1'b1, tick = 1'b0;
   int bad_count = 0, samples_checked = 0, cyc = 0, n;
   gfm_axi_req_type req = '0;
   gfm_axi_rsp_type rsp;
   gfm_core_type core = '0;
   logic [4:0] pin_in, pin_out, pin_oe, ext_lvl = 5'h00, ext_oe = 5'h1F;
   gfm_act_cfg_type [1:0] act_cfg;
   logic [1:0] act_flag;
   logic [33:0] expq [$];
   logic [33:0] exp_word;
   logic [4:0] codes [9] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
      5'h0E};
   logic [17:0] pt [5] = '{{16'h0041, 2'b11}, {16'h040F, 2'b11}, {16'h0241, 2'b00},
      {16'h0201, 2'b10}, {16'h0441, 2'b10}};
   wire logic [8:0] fsel = {core.freq_loop_clock, core.divided_sys_clock_out,
      core.freq_loop_lock, core.clk_switch_done, core.servo_pair2_done,
      core.servo_pair1_done, core.wseq_idle, core.fifo_error, core.adc_lr_clock_if2};
   gfm_top #(.MIC_PULSE_CYCLES(20), .DB_TICKS(2)) DUT (.clk_in(clk_in), .reset_in(reset_in),
      .axi_req_in(req), .axi_rsp_out(rsp), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_out(pin_oe), .timeout_clock_in(tick), .core_in(core),
      .activity_cfg_out(act_cfg), .activity_flag_out(act_flag));
   gfm_pin_partner PART (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_level_in(ext_lvl),
      .ext_oe_in(ext_oe), .pin_level_out(pin_in));
   // Clock
   initial forever #2 clk_in = ~clk_in;
   // Debounce tick always running, and hang limit
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      tick <= (cyc % 4 == 0);
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   // Read data against the oldest note
   always @(negedge clk_in) if (req.rready && rsp.rvalid) begin
      exp_word = expq.pop_front();
      `CHK({rsp.rresp, rsp.rdata}, exp_word)
   end
   function automatic logic [33:0] ok(input logic [15:0] v);
      return {RESP_OKAY, 16'h0000, v};
   endfunction
   // Write cycle
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic ha, hw, hb;
      @(posedge clk_in);
      req <= '{1'b1, a, 1'b1, {16'h0000, d}, 4'hF, 1'b1, 1'b0, 12'h000, 1'b0};
      hb = 1'b0;
      while (!hb) begin
         @(negedge clk_in);
         ha = req.awvalid && rsp.awready;
         hw = req.wvalid && rsp.wready;
         hb = req.bready && rsp.bvalid;
         if (hb) `CHK(rsp.bresp, RESP_OKAY)
         @(posedge clk_in);
         if (ha) req.awvalid <= 1'b0;
         if (hw) req.wvalid <= 1'b0;
      end
      req.bready <= 1'b0;
   endtask
   // Read cycle, expected word noted first
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      logic ha, hr;
      expq.push_back(e);
      @(posedge clk_in);
      req <= '{1'b0, 12'h000, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
      hr = 1'b0;
      while (!hr) begin
         @(negedge clk_in);
         ha = req.arvalid && rsp.arready;
         hr = req.rready && rsp.rvalid;
         @(posedge clk_in);
         if (ha) req.arvalid <= 1'b0;
      end
      req.rready <= 1'b0;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(61));
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (30) @(posedge clk_in);
      rd(12'h700, ok(16'h8101));
      ext_oe <= 5'h1C;
      foreach (pt[i]) begin
         wr(12'h700, pt[i][17:2]);
         repeat (3) @(negedge clk_in);
         `CHK({pin_oe[0], pin_out[0]}, pt[i][1:0])
      end
      rd(12'h700, ok(16'h0441));
      for (n = 0; n < 9; n++) begin
         wr(12'h704, {11'h000, codes[n]});
         repeat (3) begin
            @(posedge clk_in);
            core <= 17'($urandom);
            repeat (4) @(negedge clk_in);
            `CHK(pin_out[1], fsel[n])
         end
      end
      @(posedge clk_in);
      core <= '0;
      wr(12'h704, 16'h0001);
      repeat (30) @(posedge clk_in);
      wr(12'h720, 16'h01FF);
      wr(12'h708, 16'h8501);
      ext_lvl <= 5'h04;
      repeat (40) @(posedge clk_in);
      rd(12'h708, ok(16'h8541));
      rd(12'h720, ok(16'h0004));
      wr(12'h704, 16'h0002);
      repeat (3) @(negedge clk_in);
      `CHK(pin_out[1], 1'b1)
      repeat (30) @(posedge clk_in);
      wr(12'h720, 16'h01FF);
      @(negedge clk_in);
      `CHK(pin_out[1], 1'b0)
      wr(12'h704, 16'h0003);
      core.mic_event <= 1'b1;
      n = 0;
      repeat (40) begin
         @(negedge clk_in);
         n += pin_out[1];
      end
      `CHK(n, 20)
      rd(12'h720, ok(16'h0022));
      core.range_controller_en <= 2'b01;
      core.activity_raw <= 2'b01;
      wr(12'h440, 16'h18C0);
      repeat (3) @(negedge clk_in);
      `CHK(act_cfg[0].threshold_ddb, -16'sd345)
      `CHK(act_flag, 2'b01)
      `CHK(act_cfg[0].en, 1'b1)
      wr(12'h550, 16'hF880);
      repeat (3) @(negedge clk_in);
      `CHK({act_cfg[1].en, act_cfg[1].threshold_ddb}, {1'b0, 16'hFD03})
      wr(12'h440, 16'h0440);
      repeat (3) @(negedge clk_in);
      `CHK({act_cfg[0].mode, act_cfg[0].threshold_ddb}, {1'b0, 16'sd240})
      wr(12'h704, 16'h0005);
      repeat (3) @(negedge clk_in);
      `CHK(pin_out[1], 1'b1)
      rd(12'h720, ok(16'h00A2));
      rd(12'h100, {RESP_SLVERR, 32'h0000_0000});
      results();
   end
endmodule
`default_nettype wire
